//--- reset_config_pkg.sv
// constants for the reset, strap and utility bus controller
package reset_config_pkg;
    // reset and pulse lengths in system clock cycles
    localparam logic [4:0]  LOAD_CYCLES    = 5'h10; // strap load window
    localparam logic [4:0]  PHY_RST_CYCLES = 5'h10; // control_a pulse
    localparam logic [4:0]  SW_RST_CYCLES  = 5'h10; // in-band reset hold
    localparam logic [3:0]  SW_RESET_MSG   = 4'h3;  // in-band reset type
    localparam logic [5:0]  UB_MAX_BYTES   = 6'h20; // utility burst max
    localparam logic [2:0]  TAG_MAX        = 3'h4;  // largest tag size
    localparam logic [31:0] NULL_PTR       = 32'h0000_0000; // table fill
    // strap pin positions
    localparam int STRAP_TX_SIZE_LSB = 0;
    localparam int STRAP_TX_LOC      = 3;
    localparam int STRAP_TX_HEC      = 4;
    localparam int STRAP_RX_SIZE_LSB = 5;
    localparam int STRAP_RX_HEC      = 8;
    localparam int STRAP_DPI_DIR     = 9;
    localparam int STRAP_PROG_DIR    = 10;
    localparam int STRAP_EE_INIT     = 11;
    // field positions in transmit_tag_config
    localparam int TX_SIZE_LSB = 0;
    localparam int TX_LOC      = 3;
    localparam int TX_HEC      = 4;
    // field positions in receive_tag_and_mode_select
    localparam int RX_SIZE_LSB = 0;
    localparam int RX_HEC      = 3;
    localparam int RX_DPI_DIR  = 4;
    localparam int RX_PROG_DIR = 5;
    localparam int RX_EE_INIT  = 6;
    // reset values
    localparam logic [7:0] TX_TAG_RESET = 8'h00;
    localparam logic [7:0] RX_TAG_RESET = 8'h00;
    localparam logic [7:0] TX_TAG_MASK  = 8'h1f; // upper bits read zero
    localparam logic [7:0] RX_TAG_MASK  = 8'h7f; // bit 7 reads zero
    // utility bus sequencer states
    typedef enum logic [2:0] {
        UB_IDLE   = 3'b000,
        UB_ADDR   = 3'b001,
        UB_LATCH  = 3'b010,
        UB_STROBE = 3'b011,
        UB_HOLD   = 3'b100,
        UB_GAP    = 3'b101
    } ub_state_type;
endpackage : reset_config_pkg

//--- reset_config_phy_bus_ctrl.sv
// reset sequencing, strap capture, cell filter and phy utility bus master
`timescale 1ns/1ps
module reset_config_phy_bus_ctrl (
    input  wire logic        core_clk,        // system clock
    input  wire logic        rst_n,           // system reset pin
    input  wire logic [11:0] strap_in,        // address pins at reset
    output logic             pins_oe,         // high: outputs enabled
    output logic             core_reset_n,    // device logic reset
    // in-band programming requests
    input  wire logic        msg_valid,       // in-band message seen
    input  wire logic [3:0]  msg_type,        // in-band message type
    input  wire logic        tx_tag_wr,       // write transmit tag reg
    input  wire logic        rx_tag_wr,       // write receive tag reg
    input  wire logic        filter_wr,       // write filter bit
    input  wire logic        control_a_wr,    // write one to control_a
    input  wire logic        table_reset_wr,  // write one to table reset
    input  wire logic [7:0]  cfg_wdata,       // register write data
    input  wire logic [13:0] table_entries,   // search table size
    // configuration view
    output logic [7:0]       transmit_tag_config,
    output logic [7:0]       receive_tag_and_mode_select,
    output logic             tx_tag_ok,       // tx tag size legal
    output logic             rx_tag_ok,       // rx tag size legal
    output logic             dpi_clock_direction, // 1 clock is input
    output logic             prog_on_receive, // in-band on receive side
    output logic             eeprom_init_req, // copy header at start
    output logic             receive_cell_filter,
    output logic             control_a,       // control_a in progress
    // receive cell filter
    input  wire logic        rx_cell_valid,   // receive cell offered
    input  wire logic        rx_cell_prog,    // cell is in-band type
    output logic             rx_cell_drop,    // discard this cell
    output logic             rx_prog_take,    // hand to in-band parser
    output logic             rx_count_en,     // receive counters run
    // search table fill
    output logic             table_busy,      // fill in progress
    output logic             table_we,        // write strobe to sram
    output logic [13:0]      table_addr,      // entry being written
    output logic [31:0]      table_data,      // null pointer value
    // utility bus command side
    input  wire logic        ub_req,          // start a transfer
    input  wire logic        ub_write,        // 1 write, 0 read
    input  wire logic [7:0]  ub_start_addr,   // first phy register
    input  wire logic [5:0]  ub_count,        // bytes, 1 to 32
    input  wire logic [7:0]  ub_wdata,        // byte to write
    output logic             ub_wdata_take,   // ub_wdata consumed
    output logic [7:0]       ub_rdata,        // byte read back
    output logic             ub_rvalid,       // ub_rdata new
    output logic             ub_busy,         // transfer running
    output logic             ub_done,         // transfer finished
    // utility bus pins
    output logic             phy_select_n,    // chip select
    output logic             ale,             // address latch strobe
    output logic             rd_n,            // read strobe
    output logic             wr_n,            // write strobe
    output logic [7:0]       ad_out,          // bus drive value
    output logic             ad_oe,           // bus drive enable
    input  wire logic [7:0]  ad_in,           // bus level
    output logic             control_a_n,     // control_a pin
    input  wire logic        phy_irq_n,       // phy interrupt pin
    output logic             phy_irq          // phy interrupt pending
);
    // register state of the block apart from the two reset synchroniser flops
    typedef struct packed {
        logic [4:0]  load_cnt;   // strap load cycles left
        logic [4:0]  sw_cnt;     // in-band reset cycles left
        logic [4:0]  phy_cnt;    // control_a cycles left
        logic [7:0]  tx_tag;     // transmit_tag_config
        logic [7:0]  rx_tag;     // receive_tag_and_mode_select
        logic        filter;     // receive_cell_filter
        logic        fill;       // table fill running
        logic [13:0] fill_addr;  // next entry
        logic [13:0] fill_last;  // final entry
        reset_config_pkg::ub_state_type ub;
        logic        ub_wr;      // transfer direction
        logic [7:0]  ub_addr;    // current phy register
        logic [5:0]  ub_left;    // bytes still to move
        logic [7:0]  ub_wbyte;   // latched write byte
        logic [7:0]  ub_rbyte;   // last read byte
        logic        ub_rv;      // read byte strobe
        logic        ub_dn;      // done strobe
        logic        irq;        // registered interrupt level
    } state_type;

    state_type state;       // registered state
    state_type next_state;  // next state
    logic      rst_meta;    // first reset release stage
    logic      rst_sync_n;  // synchronised reset release
    logic      loading;     // strap load window
    logic      dev_reset;   // device in reset
    logic [5:0] count_eff;  // clamped burst length

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign loading   = state.load_cnt != 5'h00;
    assign dev_reset = loading || (state.sw_cnt != 5'h00);
    // zero or oversize bursts are held inside one to 32 bytes
    assign count_eff = (ub_count == 6'h00) ? 6'h01 :
        (ub_count > reset_config_pkg::UB_MAX_BYTES) ?
        reset_config_pkg::UB_MAX_BYTES : ub_count;

    // next state of every register
    always_comb begin
        next_state       = state;
        next_state.ub_rv = 1'b0;
        next_state.ub_dn = 1'b0;
        next_state.irq   = !phy_irq_n;
        // strap capture on the first cycle of the load window
        if (loading) begin
            next_state.load_cnt = state.load_cnt - 5'h01;
            if (state.load_cnt == reset_config_pkg::LOAD_CYCLES) begin
                next_state.tx_tag = {3'b000,
                    strap_in[reset_config_pkg::STRAP_TX_HEC],
                    strap_in[reset_config_pkg::STRAP_TX_LOC],
                    strap_in[reset_config_pkg::STRAP_TX_SIZE_LSB +: 3]};
                next_state.rx_tag = {1'b0,
                    strap_in[reset_config_pkg::STRAP_EE_INIT],
                    strap_in[reset_config_pkg::STRAP_PROG_DIR],
                    strap_in[reset_config_pkg::STRAP_DPI_DIR],
                    strap_in[reset_config_pkg::STRAP_RX_HEC],
                    strap_in[reset_config_pkg::STRAP_RX_SIZE_LSB +: 3]};
            end
        end else begin
            // in-band reset restarts core logic, phy and filter kept
            if (state.sw_cnt != 5'h00) begin
                next_state.sw_cnt = state.sw_cnt - 5'h01;
            end else if (msg_valid &&
                    msg_type == reset_config_pkg::SW_RESET_MSG) begin
                next_state.sw_cnt = reset_config_pkg::SW_RST_CYCLES;
            end
            // register writes from in-band cells
            if (tx_tag_wr) begin
                next_state.tx_tag = cfg_wdata &
                    reset_config_pkg::TX_TAG_MASK;
            end
            if (rx_tag_wr) begin
                next_state.rx_tag = cfg_wdata &
                    reset_config_pkg::RX_TAG_MASK;
            end
            if (filter_wr) begin
                next_state.filter = cfg_wdata[0];
            end
            // control_a pulse, new request ignored while running
            if (state.phy_cnt != 5'h00) begin
                next_state.phy_cnt = state.phy_cnt - 5'h01;
            end else if (control_a_wr && cfg_wdata[0]) begin
                next_state.phy_cnt = reset_config_pkg::PHY_RST_CYCLES;
            end
            // null pointer fill of the search table
            if (state.fill) begin
                next_state.fill_addr = state.fill_addr + 14'h0001;
                if (state.fill_addr == state.fill_last) begin
                    next_state.fill = 1'b0;
                end
            end else if (table_reset_wr && cfg_wdata[0]) begin
                next_state.fill      = 1'b1;
                next_state.fill_addr = 14'h0000;
                next_state.fill_last = (table_entries == 14'h0000) ?
                    14'h0000 : table_entries - 14'h0001;
            end
        end
        // utility bus sequencer, one address and data phase per byte
        unique case (state.ub)
            reset_config_pkg::UB_IDLE: begin
                if (ub_req && !dev_reset) begin
                    next_state.ub      = reset_config_pkg::UB_ADDR;
                    next_state.ub_wr   = ub_write;
                    next_state.ub_addr = ub_start_addr;
                    next_state.ub_left = count_eff;
                end
            end
            reset_config_pkg::UB_ADDR: begin
                // write byte fetched while address is on the bus
                if (state.ub_wr) begin
                    next_state.ub_wbyte = ub_wdata;
                end
                next_state.ub = reset_config_pkg::UB_LATCH;
            end
            reset_config_pkg::UB_LATCH: begin
                next_state.ub = reset_config_pkg::UB_STROBE;
            end
            reset_config_pkg::UB_STROBE: begin
                next_state.ub = reset_config_pkg::UB_HOLD;
            end
            reset_config_pkg::UB_HOLD: begin
                if (!state.ub_wr) begin
                    next_state.ub_rbyte = ad_in;
                    next_state.ub_rv    = 1'b1;
                end
                next_state.ub_left = state.ub_left - 6'h01;
                next_state.ub_addr = state.ub_addr + 8'h01;
                next_state.ub      = reset_config_pkg::UB_GAP;
            end
            reset_config_pkg::UB_GAP: begin
                if (state.ub_left == 6'h00) begin
                    next_state.ub    = reset_config_pkg::UB_IDLE;
                    next_state.ub_dn = 1'b1;
                end else begin
                    next_state.ub = reset_config_pkg::UB_ADDR;
                end
            end
            default: begin
                next_state.ub = reset_config_pkg::UB_IDLE;
            end
        endcase
        // an in-band reset abandons any running transfer
        if (dev_reset) begin
            next_state.ub = reset_config_pkg::UB_IDLE;
        end
    end

    // state register; hardware reset clears the filter
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state          <= '0;
            state.load_cnt <= reset_config_pkg::LOAD_CYCLES;
            state.tx_tag   <= reset_config_pkg::TX_TAG_RESET;
            state.rx_tag   <= reset_config_pkg::RX_TAG_RESET;
            state.filter   <= 1'b0;
            state.ub       <= reset_config_pkg::UB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // pins float during reset and load, phy held through reset and load but not in-band reset
    assign pins_oe      = rst_sync_n && !loading;
    assign core_reset_n = rst_sync_n && !dev_reset;
    assign control_a_n  = rst_sync_n && !loading &&
        (state.phy_cnt == 5'h00);
    assign control_a    = state.phy_cnt != 5'h00;

    // configuration fields
    assign transmit_tag_config         = state.tx_tag;
    assign receive_tag_and_mode_select = state.rx_tag;
    assign tx_tag_ok = state.tx_tag[reset_config_pkg::TX_SIZE_LSB +: 3]
        <= reset_config_pkg::TAG_MAX;
    assign rx_tag_ok = state.rx_tag[reset_config_pkg::RX_SIZE_LSB +: 3]
        <= reset_config_pkg::TAG_MAX;
    assign dpi_clock_direction =
        state.rx_tag[reset_config_pkg::RX_DPI_DIR];
    assign prog_on_receive = state.rx_tag[reset_config_pkg::RX_PROG_DIR];
    assign eeprom_init_req = state.rx_tag[reset_config_pkg::RX_EE_INIT];
    assign receive_cell_filter = state.filter;

    // receive filter: data cells dropped, in-band cells still taken when prog_on_receive is set
    assign rx_prog_take = rx_cell_valid && rx_cell_prog &&
        prog_on_receive;
    assign rx_cell_drop = rx_cell_valid && state.filter &&
        !rx_prog_take;
    assign rx_count_en  = !state.filter && !dev_reset;

    // search table write port
    assign table_busy = state.fill;
    assign table_we   = state.fill;
    assign table_addr = state.fill_addr;
    assign table_data = reset_config_pkg::NULL_PTR;

    // utility bus pins from the sequencer state
    always_comb begin
        phy_select_n  = 1'b1;
        ale           = 1'b0;
        rd_n          = 1'b1;
        wr_n          = 1'b1;
        ad_out        = state.ub_addr;
        ad_oe         = 1'b0;
        ub_wdata_take = 1'b0;
        unique case (state.ub)
            reset_config_pkg::UB_ADDR: begin
                phy_select_n  = 1'b0;
                ale           = 1'b1;
                ad_oe         = 1'b1;
                ub_wdata_take = state.ub_wr;
            end
            reset_config_pkg::UB_LATCH: begin
                phy_select_n = 1'b0;
                ad_oe        = 1'b1;
            end
            reset_config_pkg::UB_STROBE,
            reset_config_pkg::UB_HOLD: begin
                phy_select_n = 1'b0;
                rd_n         = state.ub_wr;
                wr_n         = !state.ub_wr;
                ad_out       = state.ub_wbyte;
                ad_oe        = state.ub_wr;
            end
            default: begin
                phy_select_n = 1'b1;
            end
        endcase
        if (!pins_oe) begin
            ad_oe = 1'b0;
        end
    end

    assign ub_rdata = state.ub_rbyte;
    assign ub_rvalid = state.ub_rv;
    assign ub_done  = state.ub_dn;
    assign ub_busy  = state.ub != reset_config_pkg::UB_IDLE;
    assign phy_irq  = state.irq;

    // checks on the behaviour above
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    // load window lasts sixteen cycles after release
    property p_load_window;
        $rose(rst_sync_n) |-> !pins_oe [*8] ##1 !pins_oe [*8] ##1 pins_oe;
    endproperty
    a_load_window: assert property (p_load_window)
        else $error("strap load window length wrong");

    // phy pulse is sixteen cycles then bit clears
    sequence s_phy_low;
        !control_a_n [*8] ##1 !control_a_n [*8];
    endsequence
    property p_phy_pulse;
        $rose(control_a) |-> s_phy_low ##1 (control_a_n && !control_a);
    endproperty
    a_phy_pulse: assert property (p_phy_pulse)
        else $error("control_a pulse length wrong");

    // in-band reset holds core reset but leaves phy and filter
    property p_sw_reset;
        (!loading && state.sw_cnt == 5'h00 && msg_valid &&
         msg_type == reset_config_pkg::SW_RESET_MSG && !control_a &&
         !filter_wr && !control_a_wr)
        |=> !core_reset_n && control_a_n && $stable(receive_cell_filter);
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("in-band reset touched phy or filter");

    // filter stops counting and drops data cells
    property p_filter;
        (receive_cell_filter && rx_cell_valid && !rx_cell_prog)
        |-> rx_cell_drop && !rx_count_en;
    endproperty
    a_filter: assert property (p_filter)
        else $error("data cell passed while filtered");

    // chip select high whenever the sequencer is idle
    property p_select_idle;
        !ub_busy |-> phy_select_n && rd_n && wr_n && !ale;
    endproperty
    a_select_idle: assert property (p_select_idle)
        else $error("select active outside transfer");

    // address strobe then falling latch with address still driven
    sequence s_addr_phase;
        ale && !phy_select_n && ad_oe ##1 !ale && ad_oe;
    endsequence
    property p_addr_phase;
        $rose(ale) |-> s_addr_phase ##1 (!rd_n || !wr_n);
    endproperty
    a_addr_phase: assert property (p_addr_phase)
        else $error("address phase malformed");

    // read strobe always with bus released
    property p_read_release;
        !rd_n |-> !ad_oe && !phy_select_n;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("bus driven during read strobe");

    // write strobe with latched byte on the bus
    property p_write_drive;
        !wr_n |-> ad_oe && ad_out == state.ub_wbyte && !phy_select_n;
    endproperty
    a_write_drive: assert property (p_write_drive)
        else $error("write data not driven");

    // address steps by one between bytes
    property p_addr_step;
        (state.ub == reset_config_pkg::UB_HOLD)
        |=> state.ub_addr == $past(state.ub_addr) + 8'h01;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("burst address did not step");

    // busy fill ignores a new table reset
    property p_fill_busy;
        (table_busy && table_addr != state.fill_last)
        |=> table_busy && table_addr == $past(table_addr) + 14'h0001;
    endproperty
    a_fill_busy: assert property (p_fill_busy)
        else $error("table fill restarted while busy");
endmodule : reset_config_phy_bus_ctrl

//--- phy_bus_model.sv
// behavioural phy register file answering on the utility bus
`timescale 1ns/1ps
module phy_bus_model (
    input  wire logic       core_clk,     // system clock
    input  wire logic       phy_select_n, // chip select from the block
    input  wire logic       ale,          // address latch strobe
    input  wire logic       rd_n,         // read strobe
    input  wire logic       wr_n,         // write strobe
    input  wire logic [7:0] ad_bus,       // resolved bus level
    output logic      [7:0] phy_drv       // phy drive value
);
    logic [7:0] regs [256];  // phy registers
    logic [7:0] addr;        // latched register address
    logic [7:0] last = 8'h00; // last value put on the bus
    // bus ignored unless selected; address kept as strobe falls
    always @(posedge core_clk) begin
        if (!phy_select_n && ale) addr <= ad_bus;
        if (!phy_select_n && !wr_n) regs[addr] <= ad_bus;
        last <= phy_drv;
    end
    // drive only under select and read, else a changing pattern
    always_comb begin
        if (!phy_select_n && !rd_n) phy_drv = regs[addr];
        else phy_drv = ~last;
    end
endmodule : phy_bus_model

//--- reset_config_phy_bus_ctrl_tb_top.sv
// self-checking bench for the reset, strap and utility bus block
`timescale 1ns/1ps
module reset_config_phy_bus_ctrl_tb_top;
    logic core_clk = 0, rst_n = 0, msg_valid = 0, tx_tag_wr = 0;
    logic rx_tag_wr = 0, filter_wr = 0, control_a_wr = 0;
    logic table_reset_wr = 0, rx_cell_valid = 0, rx_cell_prog = 0;
    logic ub_req = 0, ub_write = 0, phy_irq_n = 1;
    logic pins_oe, core_reset_n, tx_tag_ok, rx_tag_ok, eeprom_init_req;
    logic dpi_clock_direction, prog_on_receive, receive_cell_filter;
    logic control_a, rx_cell_drop, rx_prog_take, rx_count_en, table_busy;
    logic table_we, ub_wdata_take, ub_rvalid, ub_busy, ub_done, ale, rd_n;
    logic phy_select_n, wr_n, ad_oe, control_a_n, phy_irq;
    logic [7:0] transmit_tag_config, receive_tag_and_mode_select, ad_out;
    logic [7:0] ub_rdata, cfg_wdata = 8'h00, ub_start_addr = 8'h00;
    logic [7:0] ub_wdata = 8'h3c, phy_drv, rq[$];
    logic [3:0] msg_type = 4'h0;
    logic [5:0] ub_count = 6'h00;
    logic [13:0] table_entries = 14'h0005, table_addr;
    logic [31:0] table_data;
    logic [11:0] strap_in = 12'ha5c; // straps seen at reset
    wire logic [7:0] ad_in = ad_oe ? ad_out : phy_drv; // bus level
    int fails = 0, n_tests = 0, cyc = 0, n;
    reset_config_phy_bus_ctrl reset_config_phy_bus_ctrl_i (.*);
    phy_bus_model phy_bus_model_i (.core_clk(core_clk),
        .phy_select_n(phy_select_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .ad_bus(ad_in), .phy_drv(phy_drv));
    // clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end
    // next write byte once the current one is consumed; read capture
    always @(posedge core_clk) begin
        if (ub_wdata_take) ub_wdata <= ub_wdata + 8'h11;
        if (ub_rvalid) rq.push_back(ub_rdata);
    end
    // compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle write pulse: 1 rx tag, 2 filter, 3 phy, 4 table, 5 tx tag
    task automatic cfg(input int k, input logic [7:0] d);
        @(posedge core_clk);
        cfg_wdata <= d;
        rx_tag_wr <= (k == 1);
        filter_wr <= (k == 2);
        control_a_wr <= (k == 3);
        table_reset_wr <= (k == 4);
        tx_tag_wr <= (k == 5);
        @(posedge core_clk);
        {rx_tag_wr, filter_wr, control_a_wr, table_reset_wr} <= 4'h0;
        tx_tag_wr <= 1'b0;
    endtask : cfg
    // cycles of control_a low, core reset low or table writes
    task automatic count(input int k, output int c);
        c = 0;
        repeat (40) begin
            @(negedge core_clk);
            c += (k == 0) ? !control_a_n : (k == 1) ? !core_reset_n : table_we;
        end
    endtask : count
    // one utility bus transfer, waiting for its completion pulse
    task automatic ub(input logic w, input logic [7:0] a, input logic [5:0] c);
        @(posedge core_clk);
        {ub_req, ub_write, ub_start_addr, ub_count} <= {1'b1, w, a, c};
        @(posedge core_clk);
        ub_req <= 1'b0;
        repeat (200) begin
            @(posedge core_clk);
            #1;
            if (ub_done) break;
        end
        chk(ub_done, 1'b1);
    endtask : ub
    // verdict and end of run
    task automatic give_verdict();
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1 chk(pins_oe, 1'b0);
        chk(control_a_n, 1'b0);
        repeat (12) @(posedge core_clk);
        #1 chk(pins_oe, 1'b1);
        chk(transmit_tag_config, 8'h1c);
        chk(receive_tag_and_mode_select, 8'h52);
        chk({dpi_clock_direction, eeprom_init_req, tx_tag_ok}, 3'h7);
        chk(receive_cell_filter, 1'b0);
        fork
            count(0, n);
            begin
                cfg(3, 8'h01);
                repeat (5) @(posedge core_clk);
                cfg(3, 8'h01);
            end
        join
        chk(n, 16);
        chk(control_a, 1'b0);
        cfg(2, 8'h01);
        rx_cell_valid <= 1'b1;
        rx_cell_prog <= 1'b1;
        #1 chk({rx_cell_drop, rx_prog_take, rx_count_en}, 3'h4);
        cfg(1, 8'h20);
        #1 chk({rx_cell_drop, rx_prog_take}, 2'h1);
        chk(rx_tag_ok, 1'b1);
        rx_cell_prog <= 1'b0;
        #1 chk({rx_cell_drop, rx_prog_take, rx_count_en}, 3'h4);
        cfg(5, 8'hff);
        #1 chk({transmit_tag_config, tx_tag_ok}, 9'h03e);
        fork
            count(1, n);
            begin
                @(posedge core_clk);
                {msg_valid, msg_type} <= {1'b1, 4'h3};
                @(posedge core_clk);
                msg_valid <= 1'b0;
            end
        join
        chk(n, 16);
        chk({receive_cell_filter, control_a_n}, 2'h3);
        fork
            count(2, n);
            cfg(4, 8'h01);
        join
        chk(n, 5);
        ub(1'b1, 8'hfe, 6'h03);
        ub(1'b0, 8'hfe, 6'h03);
        chk(rq.size(), 3);
        foreach (rq[i]) chk(rq[i], 8'h3c + 8'h11 * i);
        chk(phy_select_n, 1'b1);
        phy_irq_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(phy_irq, 1'b1);
        give_verdict();
    end
endmodule : reset_config_phy_bus_ctrl_tb_top
